// ---- logic/gcd_pkg.sv ----
// Purpose: constants for the global configuration and diagnostic routing block
// Assumes: one 100 MHz clock, plain register port
// Notes:   bits 12..16 of the configuration word are stored and passed out unchanged
// Behaviour
// - all register bits zero after reset, except noted
// - bit 0 enables recalibration while driver disabled
// - bit 1 selects standstill timeout 2^18 or 2^20
// - bit 2 enables voltage pwm chopper mode
// - bit 3 enables step filtering, resets to one
// - bit 4 inverts motor direction
// - bit 5 routes driver errors to output a
// - output a active low during reset
// - bit 6 routes prewarning to output a
// - bit 7 routes stall to output a
// - mode low: output a interrupt or step
// - bit 8 routes stall to output b
// - mode low: output b compare or direction
// - bit 9 routes index position to output b
// - bit 10 routes chopper on-state to output b
// - bit 11 toggles output b on skipped steps
package gcd_pkg;
  localparam int          GCD_ADDR_W     = 7;
  localparam int          GCD_DATA_W     = 32;
  localparam int          GCD_CFG_W      = 17;
  localparam logic [6:0]  GCD_GLOBAL_CFG_ADDR = 7'h00;
  localparam logic [7:0]  GCD_WRITE_FLAG = 8'h80;
  localparam logic [16:0] GCD_CFG_RESET  = 17'h00008;
  localparam int          GCD_B_RECAL    = 0;
  localparam int          GCD_B_FASTSS   = 1;
  localparam int          GCD_B_PWM      = 2;
  localparam int          GCD_B_FILT     = 3;
  localparam int          GCD_B_INVDIR   = 4;
  localparam int          GCD_B_A_ERR    = 5;
  localparam int          GCD_B_A_PREW   = 6;
  localparam int          GCD_B_A_STALL  = 7;
  localparam int          GCD_B_B_STALL  = 8;
  localparam int          GCD_B_B_INDEX  = 9;
  localparam int          GCD_B_B_CHOP   = 10;
  localparam int          GCD_B_B_SKIP   = 11;
  localparam int          GCD_SS_SHORT_LOG2 = 18;
  localparam int          GCD_SS_LONG_LOG2  = 20;
  localparam logic [20:0] GCD_SS_SHORT   = 21'h040000;
  localparam logic [20:0] GCD_SS_LONG    = 21'h100000;
endpackage : gcd_pkg

// ---- logic/gcd_ss_timer.sv ----
// Purpose: standstill timeout counter restarted by each step
// Assumes: step_pulse is one cycle wide
// Notes:   limits are parameters so simulation may shorten them
`timescale 1ns/1ns
module gcd_ss_timer #(
  parameter logic [20:0] SHORT_LIMIT = gcd_pkg::GCD_SS_SHORT,
  parameter logic [20:0] LONG_LIMIT  = gcd_pkg::GCD_SS_LONG
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic srst,
  // control
  input  wire logic fast_sel,
  input  wire logic step_pulse,
  // status
  output logic      standstill
);
  import gcd_pkg::*;
  logic [20:0] cnt_reg;
  logic [20:0] limit;

  initial begin
    if (SHORT_LIMIT == 21'h0 || LONG_LIMIT == 21'h0) $error("gcd_ss_timer: zero limit");
  end

  assign limit = fast_sel ? SHORT_LIMIT : LONG_LIMIT;

  always_ff @(posedge ref_clk) begin
    if (srst || step_pulse) begin
      cnt_reg <= 21'h000000;
    end else if (cnt_reg < limit) begin
      cnt_reg <= cnt_reg + 21'h000001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      standstill <= 1'b0;
    end else begin
      standstill <= !step_pulse && (cnt_reg + 21'h000001 >= limit);
    end
  end
endmodule : gcd_ss_timer

// ---- logic/gcd_top.sv ----
// Purpose: global configuration register and diagnostic output routing
// Assumes: events arrive synchronous to ref_clk; address byte carries write flag
// Notes:   diagnostic outputs are open drain, active low, oe low while driving
`timescale 1ns/1ns
module gcd_top #(
  parameter logic [20:0] SS_SHORT = gcd_pkg::GCD_SS_SHORT,
  parameter logic [20:0] SS_LONG  = gcd_pkg::GCD_SS_LONG
) (
  // clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        srst,
  // register port
  input  wire logic [7:0]                  reg_addr,
  input  wire logic [gcd_pkg::GCD_DATA_W-1:0] reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic [gcd_pkg::GCD_DATA_W-1:0]   reg_rdata,
  // mode pin and driver state
  input  wire logic                        step_dir_mode_pin,
  input  wire logic                        driver_enable_n_pin,
  input  wire logic                        chopper_off_zero,
  // internal events
  input  wire logic                        drv_overtemp,
  input  wire logic                        drv_short_gnd,
  input  wire logic                        cp_undervolt,
  input  wire logic                        prewarn,
  input  wire logic                        stall,
  input  wire logic                        index_pos,
  input  wire logic                        chopper_on_b,
  input  wire logic                        lost_step_inc,
  input  wire logic                        irq_in,
  input  wire logic                        pos_compare,
  input  wire logic                        step_pulse,
  input  wire logic                        cmd_dir,
  // configuration to the driver core
  output logic                             recal_en,
  output logic                             pwm_mode_en,
  output logic                             step_filt_en,
  output logic                             motor_dir,
  output logic                             standstill,
  output logic [4:0]                       upper_cfg,
  // diagnostic pins
  output logic                             fault_out_a_o,
  output logic                             fault_out_a_oe_n,
  output logic                             fault_out_b_o,
  output logic                             fault_out_b_oe_n
);
  import gcd_pkg::*;

  logic [GCD_CFG_W-1:0] global_config_reg;
  logic                 step_half_reg;
  logic                 skip_tgl_reg;
  logic                 a_active;
  logic                 b_active;
  logic                 ss_flag;
  logic                 hit;

  initial begin
    if (SS_SHORT >= SS_LONG) $error("gcd_top: short timeout must be below long");
  end

  ////////////////////////////////////////////////////////////////////////////
  // register port
  assign hit = (reg_addr[6:0] == GCD_GLOBAL_CFG_ADDR);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      global_config_reg <= GCD_CFG_RESET;
    end else if (reg_wr && hit && reg_addr[7]) begin
      global_config_reg <= reg_wdata[GCD_CFG_W-1:0];
    end
  end

  // unmapped reads and reads of nothing return zero
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      reg_rdata <= '0;
    end else if (reg_rd && hit && !reg_addr[7]) begin
      reg_rdata <= {{(GCD_DATA_W-GCD_CFG_W){1'b0}}, global_config_reg};
    end else begin
      reg_rdata <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // driver core controls
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      recal_en     <= 1'b0;
      pwm_mode_en  <= 1'b0;
      step_filt_en <= 1'b1;
      motor_dir    <= 1'b0;
      upper_cfg    <= 5'h00;
    end else begin
      // recalibrate only while the bridge is off
      recal_en     <= global_config_reg[GCD_B_RECAL] && (driver_enable_n_pin || chopper_off_zero);
      // safe switch-on moment is software's duty
      pwm_mode_en  <= global_config_reg[GCD_B_PWM];
      step_filt_en <= global_config_reg[GCD_B_FILT];
      motor_dir    <= cmd_dir ^ global_config_reg[GCD_B_INVDIR];
      upper_cfg    <= global_config_reg[16:12];
    end
  end

  gcd_ss_timer #(
    .SHORT_LIMIT (SS_SHORT),
    .LONG_LIMIT  (SS_LONG)
  ) u_ss (
    .ref_clk    (ref_clk),
    .srst       (srst),
    .fast_sel   (global_config_reg[GCD_B_FASTSS]),
    .step_pulse (step_pulse),
    .standstill (ss_flag)
  );

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      standstill <= 1'b0;
    end else begin
      standstill <= ss_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // step half-rate and skip toggles
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      step_half_reg <= 1'b0;
    end else if (step_pulse) begin
      step_half_reg <= ~step_half_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      skip_tgl_reg <= 1'b0;
    end else if (lost_step_inc) begin
      skip_tgl_reg <= ~skip_tgl_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output routing, result is "pin active"
  always_comb begin
    if (step_dir_mode_pin) begin
      a_active = (global_config_reg[GCD_B_A_ERR]   && (drv_overtemp || drv_short_gnd || cp_undervolt))
              || (global_config_reg[GCD_B_A_PREW]  && prewarn)
              || (global_config_reg[GCD_B_A_STALL] && stall);
      // skip toggle is xor-ed onto the or of the other enabled sources
      b_active = ((global_config_reg[GCD_B_B_STALL] && stall)
              || (global_config_reg[GCD_B_B_INDEX] && index_pos)
              || (global_config_reg[GCD_B_B_CHOP]  && chopper_on_b))
              ^ (global_config_reg[GCD_B_B_SKIP]  && skip_tgl_reg);
    end else begin
      a_active = global_config_reg[GCD_B_A_STALL] ? step_half_reg : irq_in;
      b_active = global_config_reg[GCD_B_B_STALL] ? motor_dir : pos_compare;
    end
  end

  // open drain: pull low when active, release otherwise
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      fault_out_a_o    <= 1'b0;
      fault_out_a_oe_n <= 1'b0;
    end else begin
      fault_out_a_o    <= 1'b0;
      fault_out_a_oe_n <= ~a_active;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      fault_out_b_o    <= 1'b0;
      fault_out_b_oe_n <= 1'b1;
    end else begin
      fault_out_b_o    <= 1'b0;
      fault_out_b_oe_n <= ~b_active;
    end
  end
endmodule : gcd_top

// ---- dv/gcd_sva.sv ----
// Purpose: port assertions for gcd_top
// Assumes: one clock, sync reset, writes use the 0x80 flag
// Notes:   cfg_q mirrors the register from observed writes
`timescale 1ns/1ns
module gcd_sva (
  // clock, reset, register port
  input wire logic        ref_clk,
  input wire logic        srst,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // inputs and outputs watched
  input wire logic        step_dir_mode_pin,
  input wire logic        cmd_dir,
  input wire logic        stall,
  input wire logic        drv_overtemp,
  input wire logic        drv_short_gnd,
  input wire logic        cp_undervolt,
  input wire logic        pwm_mode_en,
  input wire logic        step_filt_en,
  input wire logic        motor_dir,
  input wire logic        fault_out_a_oe_n,
  input wire logic        fault_out_b_oe_n
);
  logic [16:0] cfg_q;
  always_ff @(posedge ref_clk) begin
    if (srst) cfg_q <= 17'h00008;
    else if (reg_wr && reg_addr == 8'h80) cfg_q <= reg_wdata[16:0];
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  sequence s_wr; reg_wr && reg_addr == 8'h80; endsequence
  sequence s_rd; reg_rd && reg_addr == 8'h00; endsequence
  chk_reset_state: assert property ($fell(srst) |-> !fault_out_a_oe_n && step_filt_en && !pwm_mode_en)
    else $error("reset state wrong");
  chk_pwm_write: assert property (s_wr |=> ##1 pwm_mode_en == $past(reg_wdata[2], 2))
    else $error("pwm enable wrong");
  chk_dir_invert: assert property (s_wr |=> ##1 motor_dir == ($past(cmd_dir) ^ $past(reg_wdata[4], 2)))
    else $error("direction wrong");
  chk_read_back: assert property (s_rd |=> reg_rdata == {15'h0000, $past(cfg_q)})
    else $error("read back wrong");
  chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data not idle");
  chk_err_route: assert property (step_dir_mode_pin && cfg_q[5] && (drv_overtemp || drv_short_gnd || cp_undervolt)
    |=> !fault_out_a_oe_n)
    else $error("error routing wrong");
  chk_stall_a: assert property (step_dir_mode_pin && cfg_q[7] && stall |=> !fault_out_a_oe_n)
    else $error("stall on a wrong");
  chk_stall_b: assert property (step_dir_mode_pin && cfg_q[8] && !cfg_q[11] && stall |=> !fault_out_b_oe_n)
    else $error("stall on b wrong");
endmodule : gcd_sva

// ---- dv/gcd_pin_model.sv ----
// Purpose: open-drain diagnostic wires with board pull-ups
// Assumes: oe_n low pulls the wire to the driven level
// Notes:   a released wire reads high through its pull-up
`timescale 1ns/1ns
module gcd_pin_model (
  // driver side
  input  wire logic fault_out_a_o,
  input  wire logic fault_out_a_oe_n,
  input  wire logic fault_out_b_o,
  input  wire logic fault_out_b_oe_n,
  // wire levels
  output logic      pin_a,
  output logic      pin_b
);
  assign pin_a = fault_out_a_oe_n ? 1'b1 : fault_out_a_o;
  assign pin_b = fault_out_b_oe_n ? 1'b1 : fault_out_b_o;
endmodule : gcd_pin_model

// ---- dv/gcd_top_tb_top.sv ----
// Purpose: self-checking bench for gcd_top
// Assumes: standstill limits shortened to 16 and 64 cycles
// Notes:   toggle outputs are checked here against the reference toggles st and sk
`timescale 1ns/1ns
module gcd_top_tb_top;
  logic        ref_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, mode = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
  logic [13:0] ev = 14'h0000;
  logic [15:0] rnd = 16'h001C;
  logic [4:0]  upper;
  logic        recal, pwm, filt, mdir, sst, ao, aoe, bo, boe, pin_a, pin_b, ea, eb;
  logic        st = 1'b0, sk = 1'b0, md = 1'b0;
  int          mismatches = 0, checked = 0, cfg = 8;
  gcd_top #(.SS_SHORT(21'h000010), .SS_LONG(21'h000040)) u_gcd_top (
    .ref_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .step_dir_mode_pin(mode),
    .driver_enable_n_pin(ev[12]), .chopper_off_zero(ev[13]), .drv_overtemp(ev[0]), .drv_short_gnd(ev[1]),
    .cp_undervolt(ev[2]), .prewarn(ev[3]), .stall(ev[4]), .index_pos(ev[5]), .chopper_on_b(ev[6]),
    .lost_step_inc(ev[7]), .irq_in(ev[8]), .pos_compare(ev[9]), .step_pulse(ev[10]), .cmd_dir(ev[11]),
    .recal_en(recal), .pwm_mode_en(pwm), .step_filt_en(filt), .motor_dir(mdir), .standstill(sst),
    .upper_cfg(upper), .fault_out_a_o(ao), .fault_out_a_oe_n(aoe), .fault_out_b_o(bo), .fault_out_b_oe_n(boe));
  gcd_pin_model u_gcd_pin_model (.fault_out_a_o(ao), .fault_out_a_oe_n(aoe), .fault_out_b_o(bo),
    .fault_out_b_oe_n(boe), .pin_a, .pin_b);
  initial forever #5 ref_clk = ~ref_clk;
  // reference toggles and direction register, kept from the rules
  always @(posedge ref_clk) begin
    st <= srst ? 1'b0 : st ^ ev[10];
    sk <= srst ? 1'b0 : sk ^ ev[7];
    md <= srst ? 1'b0 : ev[11] ^ cfg[4];
  end
  ////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic final_report();
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report
  task automatic bus(input logic [7:0] a, input logic [31:0] v, input logic w);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(a, 32'h0, 1'b0);
    check(reg_rdata, exp);
  endtask : rd
  // pulses never repeat on two edges, as the ports expect
  task automatic route(input int n);
    repeat (n) begin
      ea = mode ? !(cfg[5] && |ev[2:0] || cfg[6] && ev[3] || cfg[7] && ev[4]) : (cfg[7] ? !st : !ev[8]);
      eb = mode ? !((cfg[8] && ev[4] || cfg[9] && ev[5] || cfg[10] && ev[6]) ^ (cfg[11] && sk))
                : (cfg[8] ? !md : !ev[9]);
      @(posedge ref_clk);
      rnd = lfsr(rnd);
      ev <= {rnd[13:11], rnd[10] & ~ev[10], rnd[9:8], rnd[7] & ~ev[7], rnd[6:0]};
      #1;
      check({31'h0, pin_a}, {31'h0, ea});
      check({31'h0, pin_b}, {31'h0, eb});
    end
  endtask : route
  task automatic ss(input logic [31:0] c, input int lim);
    bus(8'h80, c, 1'b1);
    @(posedge ref_clk) ev <= 14'h0400;
    @(posedge ref_clk) ev <= 14'h0000;
    repeat (lim - 6) @(posedge ref_clk);
    #1 check({31'h0, sst}, 32'h0);
    repeat (10) @(posedge ref_clk);
    #1 check({31'h0, sst}, 32'h1);
  endtask : ss
  initial begin
    repeat (16) @(posedge ref_clk);
    #1 check({31'h0, pin_a}, 32'h0);
    @(posedge ref_clk) srst <= 1'b0;
    rd(8'h00, 32'h00000008);
    check({31'h0, filt}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      d = {rnd, lfsr(rnd)} & 32'hFFFFF7FF;
      bus(8'h80, d, 1'b1);
      cfg = d[16:0];
      rd(8'h00, cfg);
      check({31'h0, pwm}, {31'h0, d[2]});
      check({31'h0, mdir}, {31'h0, ev[11] ^ d[4]});
      check({31'h0, recal}, {31'h0, d[0] & (ev[12] | ev[13])});
      check({27'h0, upper}, {27'h0, d[16:12]});
      route(40);
    end
    bus(8'h00, 32'h0, 1'b1);
    rd(8'h00, cfg);
    rd(8'h80, 32'h0);
    rd(8'h05, 32'h0);
    bus(8'h80, 32'h00000060, 1'b1);
    cfg = 32'h60;
    @(posedge ref_clk) mode <= 1'b0;
    #1 route(40);
    bus(8'h80, 32'h00000180, 1'b1);
    cfg = 32'h180;
    @(posedge ref_clk);
    #1 route(40);
    @(posedge ref_clk) mode <= 1'b1;
    bus(8'h80, 32'h00000800, 1'b1);
    cfg = 32'h800;
    route(40);
    ss(32'h2, 16);
    ss(32'h0, 64);
    final_report();
  end
  initial begin
    #200000;
    mismatches++;
    final_report();
  end
endmodule : gcd_top_tb_top
bind gcd_top gcd_sva u_gcd_sva (.ref_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .step_dir_mode_pin, .cmd_dir, .stall, .drv_overtemp, .drv_short_gnd, .cp_undervolt, .pwm_mode_en,
  .step_filt_en, .motor_dir, .fault_out_a_oe_n, .fault_out_b_oe_n);
